// ### hw/cpu_interrupt_power_control.sv
// Core control: register file, interrupt arbitration, reset and power modes
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module cpu_interrupt_power_control
  import core_ctl_pkg::*;
#(
  parameter logic [15:0] CODE_START = 16'hfc00,
  parameter logic [15:0] RAM_END    = 16'h027f
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata_q,
  output logic                   pready_q,
  output logic                   pslverr_q,
  input  wire logic              nmi_pin,
  input  wire logic              ext_reset_n,
  input  wire logic              osc_fault,
  input  wire logic              flash_access_violation,
  input  wire logic              watchdog_expire,
  input  wire logic              flash_key_violation,
  input  wire irq_src_t          irq_src,
  input  wire logic              fetch_valid,
  input  wire logic [15:0]       fetch_addr,
  input  wire logic [15:0]       reset_vector_word,
  output clk_gate_t              clk_gate_q,
  output logic                   irq_take_q,
  output logic                   sys_reset_q,
  output logic      [15:0]       vector_addr_q,
  output logic      [4:0]        irq_prio_q
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [15:0] vec_of(input logic [4:0] prio);
    vec_of = VEC_BASE + {10'h000, prio, 1'b0};
  endfunction : vec_of

  function automatic logic fetch_illegal(input logic [15:0] a);
    logic ok;
    ok = (a >= RAM_START && a <= RAM_END) ||
         (a >= INFO_START && a <= INFO_END) || (a >= CODE_START);
    fetch_illegal = (a <= PERIPH_END) || !ok;
  endfunction : fetch_illegal

  function automatic alu_res_t alu(input alu_op_t op, input logic [15:0] a,
                                   input logic [15:0] b, input logic bw);
    logic [16:0] s;
    alu_res_t    r;
    case (op)
      alu_mov: s = {1'b0, a};
      alu_add: s = {1'b0, b} + {1'b0, a};
      alu_sub: s = {1'b0, b} + {1'b0, ~a} + 17'h00001;
      alu_and: s = {1'b0, b & a};
      default: s = 17'h00000;
    endcase
    if (bw) begin
      r.val = {8'h00, s[7:0]};
      r.c   = s[8];
      r.n   = s[7];
    end else begin
      r.val = s[15:0];
      r.c   = s[16];
      r.n   = s[15];
    end
    r.z = (r.val == 16'h0000);
    alu = r;
  endfunction : alu

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  logic        access_c;
  logic        wr_c;
  logic        hit_c;
  logic [31:0] rd_c;

  op_mode_t    mode_q;
  op_mode_t    saved_mode_q;
  logic        saved_gie_q;
  logic        in_isr_q;
  logic        dco_src_q;
  logic        boot_q;
  logic        erased_q;
  logic [2:0]  nmi_en_q;
  logic [2:0]  nmi_flag_q;
  logic [4:0]  cause_q;
  logic [3:0]  op_stat_q;
  logic [15:0] tos_q;
  logic [15:0] regs_q [16];

  // Access phase completes on the second cycle; pready is registered
  assign access_c = psel && penable && !pready_q;
  assign wr_c     = psel && penable && pready_q && pwrite;
  assign hit_c    = (paddr[1:0] == 2'b00) &&
                    ((paddr <= OFF_TOS) || (paddr >= OFF_REGS));

  always_comb begin
    rd_c = 32'h0000_0000;
    if (paddr >= OFF_REGS) begin
      // Constant generator reads as zero
      if (paddr[5:2] != REG_CG) begin
        rd_c = {16'h0000, regs_q[paddr[5:2]]};
      end
    end else begin
      case (paddr)
        OFF_CTRL:   rd_c = {27'h0, dco_src_q, 1'b0, mode_q};
        OFF_STATUS: rd_c = {21'h0, clk_gate_q, erased_q, in_isr_q,
                            saved_mode_q};
        OFF_NMI:    rd_c = {25'h0, nmi_flag_q, 1'b0, nmi_en_q};
        OFF_VECTOR: rd_c = {11'h0, irq_prio_q, vector_addr_q};
        OFF_CAUSE:  rd_c = {27'h0, cause_q};
        OFF_OPSTAT: rd_c = {28'h0, op_stat_q};
        OFF_TOS:    rd_c = {16'h0000, tos_q};
        default:    rd_c = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= access_c;
      pslverr_q <= access_c && !hit_c;
      if (access_c) begin
        prdata_q <= hit_c ? rd_c : 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] nmi_sync_q;
  logic [2:0] rst_sync_q;
  logic       nmi_lvl_q;
  logic       rst_lvl_q;
  logic       nmi_evt_c;
  logic       ext_rst_evt_c;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_sync_q <= 3'b000;
      rst_sync_q <= 3'b111;
      nmi_lvl_q  <= 1'b0;
      rst_lvl_q  <= 1'b1;
    end else begin
      nmi_sync_q <= {nmi_sync_q[1:0], nmi_pin};
      rst_sync_q <= {rst_sync_q[1:0], ext_reset_n};
      if (nmi_sync_q[1] == nmi_sync_q[2]) begin
        nmi_lvl_q <= nmi_sync_q[2];
      end
      if (rst_sync_q[1] == rst_sync_q[2]) begin
        rst_lvl_q <= rst_sync_q[2];
      end
    end
  end

  assign nmi_evt_c = nmi_sync_q[1] && nmi_sync_q[2] && !nmi_lvl_q;
  assign ext_rst_evt_c = !rst_sync_q[1] && !rst_sync_q[2] && rst_lvl_q;

  // ---------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------
  logic [7:0] mask_pend_c;
  logic       nmi_pend_c;
  logic       reset_c;
  logic       fetch_bad_c;
  logic       take_c;
  logic [4:0] prio_c;
  logic       gie_c;

  assign gie_c       = regs_q[REG_SR][SR_GIE_BIT];
  assign fetch_bad_c = fetch_valid && fetch_illegal(fetch_addr);
  assign reset_c     = boot_q || ext_rst_evt_c || watchdog_expire ||
                       flash_key_violation || fetch_bad_c;
  assign nmi_pend_c  = |(nmi_flag_q & nmi_en_q);
  // Flags stay in the peripherals; ports collapse to one request each
  assign mask_pend_c = {irq_src.comparator_flag, irq_src.watchdog_flag,
                        irq_src.capture_compare_flag,
                        irq_src.timer_overflow_flag,
                        irq_src.converter_done_flag, irq_src.serial_if_flag,
                        |irq_src.port_two_change_flags,
                        |irq_src.port_one_change_flags};

  always_comb begin
    prio_c = PRIO_RESET;
    take_c = 1'b0;
    // Lowest priority first, so the highest pending overwrites it
    for (int i = 7; i >= 0; i--) begin
      if (mask_pend_c[7-i] && gie_c) begin
        prio_c = MASK_PRIO[i];
        take_c = 1'b1;
      end
    end
    if (nmi_pend_c) begin
      prio_c = PRIO_NMI;
      take_c = 1'b1;
    end
    if (in_isr_q) begin
      take_c = 1'b0; // No nesting: handler runs to its return
    end
    if (reset_c) begin
      prio_c = PRIO_RESET;
      take_c = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt entry, return and operating mode
  // ---------------------------------------------------------------
  logic reti_c;
  assign reti_c = wr_c && paddr == OFF_RETI && in_isr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q        <= 1'b1;
      erased_q      <= 1'b0;
      mode_q        <= active_operating_mode;
      saved_mode_q  <= active_operating_mode;
      saved_gie_q   <= 1'b0;
      in_isr_q      <= 1'b0;
      dco_src_q     <= 1'b0;
      irq_take_q    <= 1'b0;
      sys_reset_q   <= 1'b0;
      vector_addr_q <= 16'h0000;
      irq_prio_q    <= 5'd0;
    end else begin
      boot_q      <= 1'b0;
      irq_take_q  <= take_c;
      sys_reset_q <= take_c && reset_c;
      if (wr_c && paddr == OFF_CTRL) begin
        dco_src_q <= pwdata[CTRL_DCO_SRC_BIT];
        // Codes beyond level 4 are ignored
        if (pwdata[2:0] <= 3'(low_power_level_4)) begin
          mode_q <= op_mode_t'(pwdata[2:0]);
        end
      end
      if (reti_c) begin
        mode_q   <= saved_mode_q;
        in_isr_q <= 1'b0;
      end
      if (take_c) begin
        vector_addr_q <= vec_of(prio_c);
        irq_prio_q    <= prio_c;
        if (reset_c) begin
          in_isr_q <= 1'b0;
          erased_q <= boot_q && reset_vector_word == ERASED_WORD;
          mode_q   <= (boot_q && reset_vector_word == ERASED_WORD) ?
                      low_power_level_4 : active_operating_mode;
        end else begin
          saved_mode_q <= mode_q;
          saved_gie_q  <= gie_c;
          in_isr_q     <= 1'b1;
          mode_q       <= active_operating_mode;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Nonmaskable flags and reset causes
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_en_q   <= NMI_EN_RST;
      nmi_flag_q <= 3'b000;
      cause_q    <= CAUSE_RST;
    end else begin
      if (wr_c && paddr == OFF_NMI) begin
        nmi_en_q <= pwdata[2:0];
      end
      if (take_c && !reset_c && nmi_pend_c) begin
        nmi_en_q <= 3'b000; // Stops a still-set flag re-entering at once
      end
      // Software clear by writing one; a new event wins
      nmi_flag_q <= (nmi_flag_q &
                     ~((wr_c && paddr == OFF_NMI) ?
                       pwdata[NMI_FLAG_LSB +: 3] : 3'b000)) |
                    {flash_access_violation, osc_fault, nmi_evt_c};
      cause_q <= (cause_q &
                  ~((wr_c && paddr == OFF_CAUSE) ? pwdata[4:0] : 5'h00)) |
                 {fetch_bad_c, flash_key_violation, watchdog_expire,
                  ext_rst_evt_c, 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // Clock gating per mode
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_gate_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    end else begin
      case (mode_q)
        active_operating_mode: clk_gate_q <= '{1'b1, 1'b1, 1'b1, 1'b1,
                                               1'b1, 1'b1};
        low_power_level_0: clk_gate_q <= '{1'b0, 1'b0, 1'b1, 1'b1,
                                           1'b1, 1'b1};
        low_power_level_1: clk_gate_q <= '{1'b0, 1'b0, 1'b1, 1'b1,
                                           dco_src_q, 1'b1};
        low_power_level_2: clk_gate_q <= '{1'b0, 1'b0, 1'b0, 1'b1,
                                           1'b1, 1'b1};
        low_power_level_3: clk_gate_q <= '{1'b0, 1'b0, 1'b0, 1'b1,
                                           1'b0, 1'b1};
        low_power_level_4: clk_gate_q <= '{1'b0, 1'b0, 1'b0, 1'b0,
                                           1'b0, 1'b0};
        default: clk_gate_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register file and one-cycle register operations
  // ---------------------------------------------------------------
  logic     op_wr_c;
  op_fmt_t  fmt_c;
  logic [2:0] src_am_c;
  logic [1:0] dst_am_c;
  logic [3:0] src_c;
  logic [3:0] dst_c;
  logic [15:0] src_val_c;
  alu_res_t res_c;
  logic     jump_c;

  assign op_wr_c  = wr_c && paddr == OFF_OP;
  assign fmt_c    = op_fmt_t'(pwdata[15:14]);
  assign src_am_c = pwdata[12:10];
  assign dst_am_c = pwdata[9:8];
  assign src_c    = pwdata[7:4];
  assign dst_c    = pwdata[3:0];
  assign src_val_c = (src_c == REG_CG) ? REG_RST : regs_q[src_c];
  assign res_c    = alu(alu_op_t'(pwdata[17:16]), src_val_c, regs_q[dst_c],
                        pwdata[13]);
  assign jump_c   = pwdata[17] || (regs_q[REG_SR][SR_Z_BIT] == pwdata[16]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        regs_q[i] <= REG_RST;
      end
      op_stat_q <= 4'h0;
      tos_q     <= REG_RST;
    end else begin
      if (wr_c && paddr >= OFF_REGS && paddr[5:2] != REG_CG) begin
        regs_q[paddr[5:2]] <= (paddr[5:2] == REG_PC) ?
                              {pwdata[15:1], 1'b0} : pwdata[15:0];
      end
      if (op_wr_c) begin
        // Bits: 3 done, 2 memory operand, 1 bad mode, 0 bad format
        op_stat_q <= 4'h8;
        if (fmt_c == fmt_jump) begin
          if (jump_c) begin
            regs_q[REG_PC] <= regs_q[REG_PC] +
                              {{5{pwdata[9]}}, pwdata[9:0], 1'b0};
          end
        end else if (src_am_c == 3'h7) begin
          op_stat_q <= 4'ha;
        end else if (fmt_c == fmt_single) begin
          // Call: push program counter, load target
          tos_q          <= regs_q[REG_PC];
          regs_q[REG_SP] <= regs_q[REG_SP] - 16'h0002;
          regs_q[REG_PC] <= {src_val_c[15:1], 1'b0};
        end else if (fmt_c != fmt_dual) begin
          op_stat_q <= 4'h9;
        end else if (src_am_c != 3'h0 || dst_am_c != 2'h0) begin
          // Memory operands are moved by the bus outside this block
          op_stat_q <= 4'hc;
        end else begin
          regs_q[dst_c] <= res_c.val;
          if (dst_c != REG_SR) begin
            regs_q[REG_SR][SR_C_BIT] <= res_c.c;
            regs_q[REG_SR][SR_Z_BIT] <= res_c.z;
            regs_q[REG_SR][SR_N_BIT] <= res_c.n;
          end
        end
      end
      if (reti_c) begin
        regs_q[REG_SR][SR_GIE_BIT] <= saved_gie_q;
      end
      if (take_c) begin
        regs_q[REG_SR][SR_GIE_BIT] <= 1'b0;
      end
    end
  end

endmodule : cpu_interrupt_power_control
`default_nettype wire

// ### common/core_ctl_pkg.sv
// Constants, types and register map of the core interrupt and power control
`default_nettype none
package core_ctl_pkg;

  // ---------------------------------------------------------------
  // Register map (byte offsets)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W     = 8;
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_STATUS = 8'h04;
  localparam logic [7:0]  OFF_NMI    = 8'h08;
  localparam logic [7:0]  OFF_VECTOR = 8'h0c;
  localparam logic [7:0]  OFF_RETI   = 8'h10;
  localparam logic [7:0]  OFF_CAUSE  = 8'h14;
  localparam logic [7:0]  OFF_OP     = 8'h18;
  localparam logic [7:0]  OFF_OPSTAT = 8'h1c;
  localparam logic [7:0]  OFF_TOS    = 8'h20;
  localparam logic [7:0]  OFF_REGS   = 8'h40;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_DCO_SRC_BIT = 4;
  localparam int unsigned NMI_FLAG_LSB     = 4;
  localparam int unsigned SR_C_BIT         = 0;
  localparam int unsigned SR_Z_BIT         = 1;
  localparam int unsigned SR_N_BIT         = 2;
  localparam int unsigned SR_GIE_BIT       = 3;
  localparam logic [2:0]  NMI_EN_RST       = 3'h0;
  localparam logic [4:0]  CAUSE_RST        = 5'h01;
  localparam logic [15:0] REG_RST          = 16'h0000;

  // ---------------------------------------------------------------
  // Register roles
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_PC = 4'h0;
  localparam logic [3:0] REG_SP = 4'h1;
  localparam logic [3:0] REG_SR = 4'h2;
  localparam logic [3:0] REG_CG = 4'h3;

  // ---------------------------------------------------------------
  // Vectors, priorities and address ranges
  // ---------------------------------------------------------------
  localparam logic [15:0] VEC_BASE    = 16'hffc0;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [4:0]  PRIO_RESET  = 5'd31;
  localparam logic [4:0]  PRIO_NMI    = 5'd30;
  localparam logic [4:0]  MASK_PRIO [8] = '{5'd27, 5'd26, 5'd25, 5'd24,
                                             5'd21, 5'd20, 5'd19, 5'd18};
  localparam logic [15:0] PERIPH_END  = 16'h01ff;
  localparam logic [15:0] RAM_START   = 16'h0200;
  localparam logic [15:0] INFO_START  = 16'h1000;
  localparam logic [15:0] INFO_END    = 16'h10ff;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    active_operating_mode, low_power_level_0, low_power_level_1,
    low_power_level_2, low_power_level_3, low_power_level_4
  } op_mode_t;

  typedef enum logic [1:0] { fmt_dual, fmt_single, fmt_jump } op_fmt_t;
  typedef enum logic [1:0] { alu_mov, alu_add, alu_sub, alu_and } alu_op_t;

  typedef struct packed {
    logic cpu_run;
    logic main_clk_en;
    logic subsystem_clk_en;
    logic aux_clk_en;
    logic digital_osc_dc_en;
    logic xtal_en;
  } clk_gate_t;

  typedef struct packed {
    logic       comparator_flag;
    logic       watchdog_flag;
    logic       capture_compare_flag;
    logic       timer_overflow_flag;
    logic       converter_done_flag;
    logic       serial_if_flag;
    logic [7:0] port_two_change_flags;
    logic [7:0] port_one_change_flags;
  } irq_src_t;

  typedef struct packed {
    logic [15:0] val;
    logic        c;
    logic        z;
    logic        n;
  } alu_res_t;

endpackage : core_ctl_pkg
`default_nettype wire

// ### verif/core_ctl_asserts.sv
// Port-level property checker for the core interrupt and power control
`timescale 1ns/1ns
`default_nettype none
module core_ctl_asserts
  import core_ctl_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready_q,
  input wire logic        ext_reset_n,
  input wire logic        watchdog_expire,
  input wire logic        fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic [15:0] reset_vector_word,
  input wire clk_gate_t   clk_gate_q,
  input wire logic        irq_take_q,
  input wire logic        sys_reset_q,
  input wire logic [15:0] vector_addr_q,
  input wire logic [4:0]  irq_prio_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // Vector selection and reset sources
  // ---------------------------------------------------------------
  property p_rst_vec;
    sys_reset_q |-> irq_take_q && irq_prio_q == 5'd31;
  endproperty
  a_rst_vec: assert property (p_rst_vec)
    else $error("reset take not at top priority");
  property p_vec_word;
    irq_take_q |-> vector_addr_q == {10'h3ff, irq_prio_q, 1'b0};
  endproperty
  a_vec_word: assert property (p_vec_word)
    else $error("vector word does not match priority");
  property p_no_src;
    irq_take_q |-> irq_prio_q >= 5'd18 &&
      !(irq_prio_q inside {5'd22, 5'd23, 5'd28, 5'd29});
  endproperty
  a_no_src: assert property (p_no_src)
    else $error("take on a vector with no source");
  property p_fetch;
    fetch_valid && fetch_addr <= 16'h01ff |=> sys_reset_q;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("illegal fetch gave no reset");
  property p_wdog;
    watchdog_expire |=> sys_reset_q;
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog expiry gave no reset");
  property p_ext;
    $fell(ext_reset_n) |-> ##[1:8] sys_reset_q;
  endproperty
  a_ext: assert property (p_ext)
    else $error("external reset not taken in time");
  // ---------------------------------------------------------------
  // Bus timing and clock gating
  // ---------------------------------------------------------------
  property p_apb;
    psel && penable && !pready_q |=> pready_q ##1 !pready_q;
  endproperty
  a_apb: assert property (p_apb)
    else $error("bus answer not a single wait state pulse");
  property p_wake;
    irq_take_q && !sys_reset_q |=> clk_gate_q.cpu_run;
  endproperty
  a_wake: assert property (p_wake)
    else $error("interrupt did not wake the cpu");
  property p_main;
    clk_gate_q.cpu_run == clk_gate_q.main_clk_en;
  endproperty
  a_main: assert property (p_main)
    else $error("main clock not tied to cpu run");
  property p_aux;
    !clk_gate_q.aux_clk_en |-> clk_gate_q == 6'h00;
  endproperty
  a_aux: assert property (p_aux)
    else $error("auxiliary stop without full shutdown");
  property p_erased;
    !$past(presetn) && reset_vector_word == 16'hffff
      |=> ##[0:1] clk_gate_q == 6'h00;
  endproperty
  a_erased: assert property (p_erased)
    else $error("erased boot did not stop all clocks");
  c_nmi: cover property (irq_take_q && irq_prio_q == 5'd30);
  c_port: cover property (irq_take_q && irq_prio_q == 5'd18);
  c_off: cover property (clk_gate_q == 6'h00);
endmodule : core_ctl_asserts

bind cpu_interrupt_power_control core_ctl_asserts core_ctl_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready_q(pready_q), .ext_reset_n(ext_reset_n),
  .watchdog_expire(watchdog_expire), .fetch_valid(fetch_valid),
  .fetch_addr(fetch_addr), .reset_vector_word(reset_vector_word),
  .clk_gate_q(clk_gate_q), .irq_take_q(irq_take_q),
  .sys_reset_q(sys_reset_q), .vector_addr_q(vector_addr_q),
  .irq_prio_q(irq_prio_q)
);
`default_nettype wire

// ### verif/periph_model.sv
// Peripheral flag model driving the maskable request lines
`timescale 1ns/1ns
`default_nettype none
module periph_model
  import core_ctl_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire irq_src_t set_mask,
  input  wire irq_src_t clr_mask,
  output var irq_src_t  flags_q
);
  // Flags stay up until the handler clears them, like real sources
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) flags_q <= '0;
    else flags_q <= (flags_q & ~clr_mask) | set_mask;
  end
endmodule : periph_model
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the core interrupt and power control block
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import core_ctl_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, ext_reset_n, osc_fault;
  logic        wd_exp, key_v, fetch_valid, pready_q, pslverr_q, nmi_p, acc_v;
  logic        irq_take_q, sys_reset_q;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata_q;
  logic [15:0] fetch_addr, rvw, vector_addr_q, rv[16];
  logic [15:0] fa[4] = '{16'h0, 16'h0400, 16'h0200, 16'hfc10};
  logic [4:0]  irq_prio_q;
  logic [5:0]  e;
  logic [5:0]  gm[4] = '{6'h0f, 6'h0d, 6'h07, 6'h05};
  clk_gate_t   clk_gate_q;
  irq_src_t    irq_src, set_m, clr_m;
  logic [32:0] exp_q[$];
  logic [5:0]  tk_q[$];
  int          error_cnt = 0, n_checks = 0, cyc = 0;

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  cpu_interrupt_power_control cpu_interrupt_power_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .nmi_pin(nmi_p),
    .ext_reset_n(ext_reset_n), .osc_fault(osc_fault),
    .flash_access_violation(acc_v), .watchdog_expire(wd_exp),
    .flash_key_violation(key_v), .irq_src(irq_src),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .reset_vector_word(rvw), .clk_gate_q(clk_gate_q),
    .irq_take_q(irq_take_q), .sys_reset_q(sys_reset_q),
    .vector_addr_q(vector_addr_q), .irq_prio_q(irq_prio_q));
  periph_model periph_model_inst (.clk(pclk), .rst_n(presetn),
    .set_mask(set_m), .clr_mask(clr_m), .flags_q(irq_src));

  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task chk(input logic [63:0] s, input logic [63:0] x);
    n_checks++;
    if (s !== x) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task take(input logic r, input logic [4:0] p);
    tk_q.push_back({r, p});
  endtask : take
  // One idle edge first, so a released strobe is never re-raised at once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [32:0] x);
    exp_q.push_back(x);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_q !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {1'b0, d});
  endtask : rd

  always @(posedge pclk) begin
    if (pready_q === 1'b1)
      chk({pslverr_q, pwrite ? 32'h0 : prdata_q},
          exp_q.pop_front());
    if (irq_take_q === 1'b1) begin
      e = tk_q.size() > 0 ? tk_q.pop_front() : 6'h00;
      chk({sys_reset_q, irq_prio_q, vector_addr_q},
          {e, 16'hffc0 + {e[4:0], 1'b0}});
    end
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(32'hefb77d5e));
    {psel, penable, pwrite, osc_fault, wd_exp, key_v, fetch_valid} = '0;
    {paddr, pwdata, fetch_addr, set_m, clr_m, nmi_p, acc_v} = '0;
    ext_reset_n = 1'b1;
    presetn = 1'b0;
    rvw = 16'($urandom) & 16'hfffe;
    fa[0] = 16'($urandom) & 16'h01ff;
    take(1'b1, 5'd31);
    tick(4);
    presetn <= 1'b1;
    for (int i = 4; i < 16; i++) begin
      rv[i] = 16'($urandom);
      wr(8'h40 + 8'(4 * i), {16'h0, rv[i]});
      rd(8'h40 + 8'(4 * i), {16'h0, rv[i]});
    end
    wr(8'h4c, 32'hffff);
    rd(8'h4c, 32'h0);
    wr(OFF_OP, 32'h0001_0045);
    rd(8'h54, {16'h0, 16'(rv[5] + rv[4])});
    wr(OFF_OP, 32'h0000_2046);
    for (int m = 1; m < 8; m++) wr(OFF_OP, 32'h0000_0076 | (32'(m) << 10));
    rd(8'h58, {24'h0, rv[4][7:0]});
    rd(OFF_OPSTAT, 32'ha);
    wr(OFF_OP, 32'h0000_4080);
    rd(8'h40, {16'h0, rv[8] & 16'hfffe});
    wr(OFF_OP, 32'h0002_8003);
    rd(8'h40, {16'h0, 16'((rv[8] & 16'hfffe) + 16'h6)});
    apb(1'b0, 8'h24, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h41, 32'h1, {1'b1, 32'h0});
    foreach (gm[m]) begin
      wr(OFF_CTRL, 32'(m + 1));
      rd(8'h04, 32'(gm[m]) << 5);
    end
    wr(OFF_CTRL, 32'h4);
    set_m <= {6'h3f, 8'($urandom) | 8'h01, 8'($urandom) | 8'h01};
    tick(1);
    set_m <= '0;
    tick(5);
    take(1'b0, MASK_PRIO[0]);
    wr(8'h48, 32'h8);
    for (int i = 0; i < 8; i++) begin
      clr_m <= i < 6 ? 22'h200000 >> i : (i == 6 ? 22'h00ff00 : 22'h0000ff);
      tick(1);
      clr_m <= '0;
      if (i < 7) take(1'b0, MASK_PRIO[i + 1]);
      wr(OFF_RETI, 32'h1);
    end
    rd(OFF_CTRL, 32'h4);
    wr(8'h48, 32'h0);
    wr(OFF_NMI, 32'h2);
    take(1'b0, 5'd30);
    {osc_fault, nmi_p, acc_v} <= 3'h7;
    tick(3);
    {osc_fault, nmi_p, acc_v} <= 3'h0;
    rd(OFF_NMI, 32'h70);
    wr(OFF_NMI, 32'h70);
    wr(OFF_RETI, 32'h1);
    rd(OFF_NMI, 32'h0);
    take(1'b1, 5'd31);
    wd_exp <= 1'b1;
    tick(1);
    wd_exp <= 1'b0;
    take(1'b1, 5'd31);
    key_v <= 1'b1;
    tick(1);
    key_v <= 1'b0;
    take(1'b1, 5'd31);
    ext_reset_n <= 1'b0;
    tick(4);
    ext_reset_n <= 1'b1;
    tick(8);
    for (int k = 0; k < 4; k++) begin
      if (k < 2) take(1'b1, 5'd31);
      fetch_valid <= 1'b1;
      fetch_addr  <= fa[k];
      tick(1);
      fetch_valid <= 1'b0;
      tick(4);
    end
    rd(OFF_CAUSE, 32'h1f);
    rvw <= 16'hffff;
    presetn <= 1'b0;
    tick(2);
    take(1'b1, 5'd31);
    presetn <= 1'b1;
    tick(3);
    rd(OFF_CTRL, 32'h5);
    rd(8'h04, 32'h10);
    tick(2);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
